/* File: verilog/serial_glue_pkg.sv */
/*
  Constants shared by the quad serial module glue logic: port count,
  module bus address decode, strobe and acknowledge timing.
  Assumes an 8-bit module bus on the glue clock; no other context.
*/
package serial_glue_pkg;
  // ===========================================================
  // sizes
  localparam int PORT_COUNT = 4;
  localparam int DATA_WIDTH = 8;
  localparam int ADDR_WIDTH = 6;
  // ===========================================================
  // address decode: uart ports 1 to 3 take 8 registers each; select 0 is a hole, so port 0 is never selected
  localparam int PORT_SEL_MSB = 5;
  localparam int PORT_SEL_LSB = 4;
  localparam logic [1:0] PORT_SEL_HOLE = 2'h0;
  localparam int REG_MSB = 2;
  // transmit-enable-always control byte sits on this I/O address
  localparam logic [5:0] ENABLE_ALWAYS_ADDR = 6'h3_F;
  localparam logic [3:0] ENABLE_ALWAYS_RESET = 4'h0;
  // ===========================================================
  // timing
  localparam int STROBE_NS = 20;
  localparam int CLK_NS = 5;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] ID_FILL = 8'h0_0;
endpackage : serial_glue_pkg

/* File: verilog/rotating_arbiter.sv */
/*
  Rotating priority arbiter for the port interrupt requests.
  Assumes requests are synchronous levels and service is a one-cycle pulse.
*/
`timescale 1ns/1ps
module rotating_arbiter #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] request_in,
  input wire logic serviced_in,
  output logic [WIDTH-1:0] grant_out
);
  // ===========================================================
  // priority pointer: index of highest-priority port
  logic [$clog2(WIDTH)-1:0] top;
  logic [WIDTH-1:0] pick;
  logic [$clog2(WIDTH)-1:0] pick_idx;

  // search from the top pointer around the ring
  always_comb begin
    pick = '0;
    pick_idx = top;
    for (int k = WIDTH - 1; k >= 0; k--) begin
      if (request_in[(int'(top) + k) % WIDTH]) begin
        pick = '0;
        pick[(int'(top) + k) % WIDTH] = 1'b1;
        pick_idx = $clog2(WIDTH)'((int'(top) + k) % WIDTH);
      end
    end
  end

  // serviced port drops to lowest, next one becomes highest
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      top <= '0;
      grant_out <= '0;
    end else if (enable_in) begin
      grant_out <= pick;
      if (serviced_in && |grant_out) begin
        top <= pick_idx + 1'b1;
      end
    end
  end

  serviced_next_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    enable_in && serviced_in && |grant_out && grant_out == pick
    |=> top == $past(pick_idx) + 1'b1)
    else $error("priority did not rotate past serviced port");
  grant_onehot_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $onehot0(grant_out))
    else $error("more than one port granted");
endmodule : rotating_arbiter

/* File: verilog/serial_glue.sv */
/*
  Glue logic of a four-port serial module: module bus decode, chip
  selects, strobes, acknowledge, line enables and interrupt arbitration.
  Assumes the module bus inputs are synchronous to clk_in and that the
  carrier waits for ack_n_out before ending a cycle.
*/
`timescale 1ns/1ps
module serial_glue #(
  parameter int STROBE_LEN = serial_glue_pkg::STROBE_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic io_sel_n_in,
  input wire logic id_sel_n_in,
  input wire logic write_n_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_out,
  output logic ack_n_out,
  output logic [7:0] uart_data_out,
  output logic uart_data_oe_out,
  input wire logic [7:0] uart_data_in,
  output logic [2:0] uart_addr_out,
  output logic [3:0] uart_cs_n_out,
  output logic uart_rd_n_out,
  output logic uart_wr_n_out,
  output logic rom_cs_n_out,
  input wire logic [7:0] rom_data_in,
  output logic [3:0] uart_ri_n_out,
  output logic [3:0] uart_dsr_n_out,
  output logic [3:0] uart_dcd_n_out,
  input wire logic [3:0] uart_dtr_n_in,
  input wire logic [3:0] uart_rts_n_in,
  input wire logic [3:0] uart_txd_in,
  input wire logic [3:0] uart_irq_in,
  output logic [3:0] rx_enable_out,
  output logic [3:0] tx_enable_out,
  output logic [3:0] line_txd_out,
  output logic [3:0] int_req_n_out,
  input wire logic int_ack_n_in
);
  // ===========================================================
  // cycle states
  typedef enum logic [1:0] {IDLE, STROBE, ACK, DONE} cycle_type;
  cycle_type state;
  cycle_type next_state;
  logic [7:0] count;
  logic [3:0] enable_always;
  logic is_write;
  logic is_id;
  logic [5:0] addr;
  logic [3:0] grant;
  logic serviced;
  logic ack_prev;

  // one decode of an address into the uart port select
  function automatic logic [3:0] port_cs(input logic [5:0] a);
    port_cs = 4'hF;
    if (a[serial_glue_pkg::PORT_SEL_MSB:serial_glue_pkg::PORT_SEL_LSB]
        != serial_glue_pkg::PORT_SEL_HOLE) begin
      port_cs[a[5:4]] = 1'b0;
    end
  endfunction : port_cs

  // ===========================================================
  // host bus decode
  wire cycle_start = ~io_sel_n_in | ~id_sel_n_in;
  // in IDLE the captured copies are not loaded yet, so decode the live bus;
  // otherwise the first strobe cycle would use the previous access
  wire [5:0] sel_addr = (state == IDLE) ? addr_in : addr;
  wire sel_id = (state == IDLE) ? ~id_sel_n_in : is_id;
  wire sel_write = (state == IDLE) ? ~write_n_in : is_write;
  wire is_ctrl = (sel_addr == serial_glue_pkg::ENABLE_ALWAYS_ADDR);
  wire [3:0] decoded_cs = (sel_id || is_ctrl) ? 4'hF : port_cs(sel_addr);
  wire uart_hit = ~&decoded_cs;
  wire strobe_done = (count == 8'(STROBE_LEN - 1));
  wire [7:0] read_mux = is_id ? rom_data_in :
                        is_ctrl ? {4'h0, enable_always} :
                        uart_hit ? uart_data_in : 8'h0_0;
  wire [3:0] next_tx_enable = ~uart_rts_n_in | enable_always;

  // access sequencer: select, hold strobe, acknowledge, wait release
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: if (cycle_start) next_state = STROBE;
      STROBE: if (strobe_done) next_state = ACK;
      ACK: next_state = DONE;
      DONE: if (!cycle_start) next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= IDLE;
      count <= 8'h0_0;
      is_write <= 1'b0;
      is_id <= 1'b0;
      addr <= 6'h0_0;
    end else if (clk_en_in) begin
      state <= next_state;
      count <= (state == STROBE) ? count + 8'h0_1 : 8'h0_0;
      if (state == IDLE && cycle_start) begin
        is_write <= ~write_n_in;
        is_id <= ~id_sel_n_in;
        addr <= addr_in;
      end
    end
  end

  // ===========================================================
  // uart and rom strobes, registered so outputs come from flops
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      uart_cs_n_out <= 4'hF;
      uart_rd_n_out <= 1'b1;
      uart_wr_n_out <= 1'b1;
      rom_cs_n_out <= 1'b1;
      uart_addr_out <= 3'h0;
      uart_data_out <= 8'h0_0;
      uart_data_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      uart_cs_n_out <= (next_state == STROBE) ? decoded_cs : 4'hF;
      uart_rd_n_out <= ~(next_state == STROBE && uart_hit && !sel_write);
      uart_wr_n_out <= ~(next_state == STROBE && uart_hit && sel_write);
      rom_cs_n_out <= ~(next_state == STROBE && sel_id && !sel_write);
      uart_addr_out <= sel_addr[serial_glue_pkg::REG_MSB:0];
      uart_data_out <= host_data_in;
      uart_data_oe_out <= next_state == STROBE && uart_hit && sel_write;
    end
  end

  // acknowledge for every access, decoded or not; read data with it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_n_out <= 1'b1;
      host_data_out <= 8'h0_0;
      host_data_oe_out <= 1'b0;
      enable_always <= serial_glue_pkg::ENABLE_ALWAYS_RESET;
    end else if (clk_en_in) begin
      ack_n_out <= ~(state == STROBE && strobe_done);
      host_data_oe_out <= state == STROBE && strobe_done && !is_write;
      if (state == STROBE && strobe_done) host_data_out <= read_mux;
      // id space writes fall through: only the control byte is writable
      if (state == STROBE && strobe_done && is_write && !is_id && is_ctrl) begin
        enable_always <= host_data_in[3:0];
      end
    end
  end

  // ===========================================================
  // line side: enables, tied-off modem inputs, data passthrough
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_enable_out <= 4'h0;
      tx_enable_out <= 4'h0;
      line_txd_out <= 4'hF;
      uart_ri_n_out <= 4'hF;
      uart_dsr_n_out <= 4'hF;
      uart_dcd_n_out <= 4'hF;
    end else if (clk_en_in) begin
      rx_enable_out <= ~uart_dtr_n_in;
      tx_enable_out <= next_tx_enable;
      // a disabled driver still presents mark so the line idles high
      line_txd_out <= uart_txd_in | ~next_tx_enable;
      uart_ri_n_out <= 4'hF;
      uart_dsr_n_out <= 4'hF;
      uart_dcd_n_out <= 4'hF;
    end
  end

  // ===========================================================
  // interrupt arbitration; service is the carrier's acknowledge edge
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_prev <= 1'b1;
      int_req_n_out <= 4'hF;
    end else if (clk_en_in) begin
      ack_prev <= int_ack_n_in;
      int_req_n_out <= ~grant;
    end
  end
  assign serviced = ack_prev & ~int_ack_n_in;

  rotating_arbiter #(
    .WIDTH(serial_glue_pkg::PORT_COUNT)
  ) arbiter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(clk_en_in),
    .request_in(uart_irq_in),
    .serviced_in(serviced),
    .grant_out(grant)
  );

  // ===========================================================
  // checks
  ack_every_cycle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state == IDLE && cycle_start ##1 clk_en_in[*4] |=> !ack_n_out)
    else $error("access not acknowledged");
  ack_one_cycle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(ack_n_out) && clk_en_in |=> ack_n_out)
    else $error("acknowledge longer than one cycle");
  rom_no_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !rom_cs_n_out |-> !is_write && uart_wr_n_out)
    else $error("rom selected on a write");
  single_select_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $onehot0(~uart_cs_n_out) && (rom_cs_n_out || &uart_cs_n_out))
    else $error("two devices selected");
  tx_enable_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> tx_enable_out == ($past(~uart_rts_n_in) | $past(enable_always)))
    else $error("transmit enable wrong");
  rx_enable_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> rx_enable_out == ~$past(uart_dtr_n_in))
    else $error("receive enable not from dtr");
  modem_tied_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    &uart_ri_n_out && &uart_dsr_n_out && &uart_dcd_n_out)
    else $error("modem input not held high");
  idle_mark_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && uart_rts_n_in == 4'hF && enable_always == 4'h0 |=> line_txd_out == 4'hF)
    else $error("line not at mark while idle");
endmodule : serial_glue

/* File: sim/module_bus_host.sv */
/*
  Carrier board host model for the module bus: one byte access per call.
  Assumes the glue registers ack_n and all strobes on clk_in.
*/
`timescale 1ns/1ps
module module_bus_host (
  input wire logic clk_in,
  input wire logic ack_n_in,
  input wire logic [7:0] data_in,
  input wire logic [3:0] cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic rom_cs_n_in,
  output logic io_sel_n_out,
  output logic id_sel_n_out,
  output logic write_n_out,
  output logic [5:0] addr_out,
  output logic [7:0] data_out
);
  logic watching = 1'b0;
  logic [6:0] seen_low = 7'h00;
  initial begin
    io_sel_n_out = 1'b1;
    id_sel_n_out = 1'b1;
    write_n_out = 1'b1;
    addr_out = 6'h00;
    data_out = 8'h00;
  end
  // ============================================================
  // strobe history of the access in flight
  always @(posedge clk_in) begin
    if (!watching) seen_low <= 7'h00;
    else seen_low <= seen_low | ~{cs_n_in, rd_n_in, wr_n_in, rom_cs_n_in};
  end
  // ============================================================
  // one access; request held until ack is sampled low or 40 clocks pass without it
  task automatic access(input logic id_space, input logic wr, input logic [5:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic [6:0] seen,
      output logic acked);
    int n;
    @(posedge clk_in);
    #1;
    watching = 1'b1;
    io_sel_n_out = id_space;
    id_sel_n_out = !id_space;
    write_n_out = !wr;
    addr_out = a;
    data_out = d;
    acked = 1'b0;
    q = 8'h00;
    for (n = 0; n < 40 && !acked; n++) begin
      @(posedge clk_in);
      if (ack_n_in === 1'b0) begin
        acked = 1'b1;
        q = data_in;
      end
    end
    #1;
    seen = seen_low;
    watching = 1'b0;
    io_sel_n_out = 1'b1;
    id_sel_n_out = 1'b1;
    write_n_out = 1'b1;
    // released lines must not look like the last value
    addr_out = ~a;
    data_out = ~d;
    @(posedge clk_in);
  endtask : access
endmodule : module_bus_host

/* File: sim/serial_glue_bench.sv */
/*
  Self-checking bench for the serial glue: bus decode, line enables, arbitration.
  Assumes the host model above and the default strobe length.
*/
`timescale 1ns/1ps
module serial_glue_bench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] dtr_n = 4'hF, rts_n = 4'hF, txd = 4'h0, irq = 4'h0;
  logic int_ack_n = 1'b1;
  logic io_n, id_n, wr_n, ack_n, rd_n_s, wr_n_s, rom_n;
  logic [5:0] addr;
  logic [7:0] hd_in, hd_out;
  logic [3:0] cs_n, ri_n, dsr_n, dcd_n, rx_en, tx_en, ltxd, req_n;
  int bad_count = 0;
  int checked = 0;
  // far end of each line: carrier stays off, so its receive data sits at mark
  wire [3:0] far_rxd = dcd_n;
  // far end raises cts only with rts, dsr and dtr all on (active low)
  wire [3:0] far_cts_n = ~(~rts_n & ~dsr_n & ~dtr_n);
  always #2.5 clk_in = ~clk_in;
  serial_glue i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .io_sel_n_in(io_n), .id_sel_n_in(id_n), .write_n_in(wr_n), .addr_in(addr),
    .host_data_in(hd_in), .host_data_out(hd_out), .host_data_oe_out(), .ack_n_out(ack_n),
    .uart_data_out(), .uart_data_oe_out(), .uart_data_in(8'h3C), .uart_addr_out(),
    .uart_cs_n_out(cs_n), .uart_rd_n_out(rd_n_s), .uart_wr_n_out(wr_n_s),
    .rom_cs_n_out(rom_n), .rom_data_in(8'hA5), .uart_ri_n_out(ri_n),
    .uart_dsr_n_out(dsr_n), .uart_dcd_n_out(dcd_n), .uart_dtr_n_in(dtr_n),
    .uart_rts_n_in(rts_n), .uart_txd_in(txd), .uart_irq_in(irq), .rx_enable_out(rx_en),
    .tx_enable_out(tx_en), .line_txd_out(ltxd), .int_req_n_out(req_n),
    .int_ack_n_in(int_ack_n));
  module_bus_host i_host (.clk_in(clk_in), .ack_n_in(ack_n), .data_in(hd_out),
    .cs_n_in(cs_n), .rd_n_in(rd_n_s), .wr_n_in(wr_n_s), .rom_cs_n_in(rom_n),
    .io_sel_n_out(io_n), .id_sel_n_out(id_n), .write_n_out(wr_n), .addr_out(addr),
    .data_out(hd_in));
  // ============================================================
  // shared helpers
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // flags are cs[3:0], rd, wr, rom, ack; mask hides don't-care strobes
  task automatic bus(input logic id, input logic wr, input logic [5:0] a,
      input logic [7:0] d, input logic [7:0] ef, input logic [7:0] mask,
      input logic [7:0] eq, input string what);
    logic [7:0] q;
    logic [6:0] s;
    logic ok;
    i_host.access(id, wr, a, d, q, s, ok);
    check({what, " flags"}, ef & mask, {s, ok} & mask);
    if (!wr) check({what, " data"}, eq, q);
  endtask : bus
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // ============================================================
  // scenarios
  task automatic t_lines;
    @(posedge clk_in);
    #1;
    dtr_n = 4'b1010;
    rts_n = 4'b0110;
    txd = 4'b0011;
    repeat (3) @(posedge clk_in);
    #1;
    check("unused modem inputs", 8'h0F, {4'h0, ri_n & dsr_n & dcd_n});
    check("rx enables", 8'h05, {4'h0, rx_en});
    check("tx enables", 8'h09, {4'h0, tx_en});
    check("line txd", 8'h07, {4'h0, ltxd});
    check("far rxd", 8'h0F, {4'h0, far_rxd});
    check("far cts", 8'h0F, {4'h0, far_cts_n});
    bus(1'b0, 1'b1, 6'h3F, 8'h04, 8'h01, 8'hFF, 8'h00, "enable write");
    repeat (2) @(posedge clk_in);
    #1;
    check("tx forced", 8'h0D, {4'h0, tx_en});
    bus(1'b0, 1'b0, 6'h3F, 8'h00, 8'h01, 8'h01, 8'h04, "enable read");
    bus(1'b0, 1'b1, 6'h3F, 8'h00, 8'h01, 8'hFF, 8'h00, "enable clear");
    $display("lines test done");
  endtask : t_lines
  task automatic t_bus;
    bus(1'b0, 1'b0, 6'h12, 8'h00, 8'h29, 8'hFF, 8'h3C, "uart read");
    bus(1'b0, 1'b1, 6'h25, 8'h96, 8'h45, 8'hFF, 8'h00, "uart write");
    bus(1'b1, 1'b0, 6'h01, 8'h00, 8'h03, 8'hFF, 8'hA5, "rom read");
    bus(1'b1, 1'b1, 6'h01, 8'h5A, 8'h01, 8'hFF, 8'h00, "rom write");
    bus(1'b0, 1'b0, 6'h05, 8'h00, 8'h01, 8'hF9, 8'h00, "hole read");
    $display("bus test done");
  endtask : t_bus
  // all four request; each service hands priority to the next port
  task automatic t_irq;
    logic [3:0] expect_n [3] = '{4'b1110, 4'b1101, 4'b1011};
    irq = 4'hF;
    for (int k = 0; k < 3; k++) begin
      repeat (4) @(posedge clk_in);
      #1;
      check("grant", {4'h0, expect_n[k]}, {4'h0, req_n});
      int_ack_n = 1'b0;
      @(posedge clk_in);
      #1;
      int_ack_n = 1'b1;
    end
    irq = 4'h0;
    $display("irq test done");
  endtask : t_irq
  // ============================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_irq;
    t_lines;
    t_bus;
    wrap_up;
  end
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
endmodule : serial_glue_bench
